/* File: testbench.sv */
// Self-checking bench of the timer block: register tasks and scenario calls.
// Assumes tmr2_pkg, tmr2_top and tmr2_far are compiled before this file.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
    import tmr2_pkg::*;
    logic       clk_i = 1'b0;
    logic       reset_i = 1'b1;
    tmr2_addr_t addr_i = 3'h0;
    tmr2_byte_t wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    tmr2_byte_t rdata_o, rv;
    logic       pin_drv = 1'b1, trig_drv = 1'b1, pin_prev = 1'b0;
    logic       pin_in, trig, t1_ovf, pin_o, oe_n, tx_tick, rx_tick, tf, exf, irq;
    int         n_errors = 0, total_checks = 0, cycles = 0, n, i;
    wire logic [5:0] ev = {~exf, exf, tf, rx_tick, tx_tick, pin_o ^ pin_prev};

    tmr2_top #(.PRESCALE_W(4)) i_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .timer_io_pin_i(pin_in), .timer_io_pin_o(pin_o), .timer_io_pin_oe_n_o(oe_n),
        .ext_trigger_pin_i(trig), .timer1_ovf_i(t1_ovf), .tx_bit_tick_o(tx_tick),
        .rx_bit_tick_o(rx_tick), .timer_overflow_flag_o(tf), .ext_event_flag_o(exf),
        .timer_irq_o(irq));
    tmr2_far i_far (.clk_i(clk_i), .reset_i(reset_i), .pin_drv_i(pin_drv),
        .trig_drv_i(trig_drv), .dut_pin_i(pin_o), .dut_oe_n_i(oe_n), .pin_in_o(pin_in),
        .trig_o(trig), .t1_ovf_o(t1_ovf));

    // ****************************************************************
    // Clock, watchdog and bus tasks.
    // ****************************************************************
    // Clock and the sample of the pin used to see its toggles.
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        pin_prev <= pin_o;
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize();
        if (n_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Each strobe rises one edge after the task starts, so calls may follow back to back.
    task automatic wr(input tmr2_addr_t a, input tmr2_byte_t d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input tmr2_addr_t a, output tmr2_byte_t d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask

    // Stops the timer, loads the counting registers, then writes control last.
    task automatic setup(input tmr2_byte_t c, md, ps, input logic [15:0] cnt, rld);
        wr(3'h0, 8'h00);
        wr(3'h1, md);
        wr(3'h6, ps);
        wr(3'h2, cnt[7:0]);
        wr(3'h3, cnt[15:8]);
        wr(3'h4, rld[7:0]);
        wr(3'h5, rld[15:8]);
        wr(3'h0, c);
    endtask

    // Counts clocks until the chosen event shows, giving up at the limit.
    task automatic wait_ev(input int sel, lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk_i);
            #1 cnt++;
        end while (ev[sel] !== 1'b1 && cnt < lim);
    endtask

    task automatic gap(input int sel, output int p);
        wait_ev(sel, 300, p);
        wait_ev(sel, 300, p);
    endtask

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        // Reset values, the unmapped address and the unused upper bits.
        for (i = 0; i < 8; i++) begin
            rd(3'(i), rv);
            `CHK("reset value", 8'h00, rv)
        end
        wr(3'h1, 8'hff);
        rd(3'h1, rv);
        `CHK("mode readback", 8'h0f, rv)
        wr(3'h7, 8'h5a);
        rd(3'h7, rv);
        `CHK("unmapped read", 8'h00, rv)
        // Up counting auto-reload wraps to the reload value and sets the flag.
        setup(8'h04, 8'h00, 8'h00, 16'hfff0, 16'hfff0);
        wait_ev(3, 40, n);
        `CHK("overflow seen", 1'b1, n < 40)
        `CHK("irq on overflow", 1'b1, irq)
        wr(3'h0, 8'h80);
        rd(3'h3, rv);
        `CHK("count high after wrap", 8'hff, rv)
        rd(3'h0, rv);
        `CHK("control flag", 8'h80, rv)
        // Counter select counts falling edges of the timer pin.
        setup(8'h06, 8'h00, 8'h00, 16'h0000, 16'h0000);
        for (i = 0; i < 5; i++) begin
            @(posedge clk_i) pin_drv <= 1'b0;
            repeat (3) @(posedge clk_i);
            pin_drv <= 1'b1;
            repeat (3) @(posedge clk_i);
        end
        rd(3'h2, rv);
        `CHK("pin edge count", 8'h05, rv)
        `CHK("pin as input", 1'b1, oe_n)
        // Up-only reload mode: a trigger falling edge reloads and sets the event flag.
        setup(8'h0c, 8'h00, 8'h0f, 16'h0100, 16'h0020);
        @(posedge clk_i) trig_drv <= 1'b0;
        wait_ev(4, 10, n);
        `CHK("event flag on edge", 1'b1, n < 10)
        `CHK("irq from event", 1'b1, irq)
        wr(3'h0, 8'h00);
        rd(3'h3, rv);
        `CHK("reloaded high byte", 8'h00, rv)
        // Up/down: down count underflows to all ones, event flag acts as bit 17.
        setup(8'h0c, 8'h01, 8'h00, 16'h0012, 16'h0010);
        wait_ev(4, 20, n);
        `CHK("underflow toggles", 1'b1, n < 20)
        `CHK("underflow flag", 1'b1, tf)
        wr(3'h0, 8'h48);
        rd(3'h3, rv);
        `CHK("count after underflow", 8'hff, rv)
        `CHK("no irq from toggle", 1'b0, irq)
        @(posedge clk_i) trig_drv <= 1'b1;
        wr(3'h0, 8'h4c);
        wait_ev(5, 300, n);
        `CHK("overflow toggles back", 1'b1, n < 300)
        // Baud generation and clock-out together, capture select overridden.
        setup(8'h15, 8'h02, 8'h00, 16'hfffc, 16'hfffc);
        gap(0, n);
        `CHK("clock-out half period", 4, n)
        gap(1, n);
        `CHK("transmit bit period", 64, n)
        gap(2, n);
        `CHK("receive from timer one", 80, n)
        `CHK("pin driven", 1'b0, oe_n)
        `CHK("no baud flag", 1'b0, tf)
        `CHK("no baud irq", 1'b0, irq)
        wr(3'h0, 8'h11);
        repeat (2) @(posedge clk_i);
        wait_ev(0, 20, n);
        `CHK("stopped pin", 20, n)
        // Baud mode trigger edge only sets the event flag.
        wr(3'h0, 8'h1d);
        @(posedge clk_i) trig_drv <= 1'b0;
        wait_ev(4, 10, n);
        `CHK("baud event flag", 1'b1, n < 10)
        gap(1, n);
        `CHK("period kept", 64, n)
        summarize();
    end
endmodule // testbench

/* File: tmr2_cfg.svh */
// Offsets, bit positions, reset values and timing counts of the timer block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef TMR2_CFG_SVH
`define TMR2_CFG_SVH

// ****************************************************************
// Register offsets (byte wide registers on a 3-bit address).
// ****************************************************************
`define TMR2_OFS_CTRL      3'h0
`define TMR2_OFS_MODE      3'h1
`define TMR2_OFS_CNT_LO    3'h2
`define TMR2_OFS_CNT_HI    3'h3
`define TMR2_OFS_RLD_LO    3'h4
`define TMR2_OFS_RLD_HI    3'h5
`define TMR2_OFS_PRESCALE  3'h6

// ****************************************************************
// Control register bit positions.
// ****************************************************************
`define TMR2_CTRL_CPRL     0
`define TMR2_CTRL_CSEL     1
`define TMR2_CTRL_RUN      2
`define TMR2_CTRL_EXEN     3
`define TMR2_CTRL_TXSEL    4
`define TMR2_CTRL_RXSEL    5
`define TMR2_CTRL_EXF      6
`define TMR2_CTRL_TF       7

// ****************************************************************
// Mode register bit positions.
// ****************************************************************
`define TMR2_MODE_DOWN     0
`define TMR2_MODE_CKOE     1
`define TMR2_MODE_CM_LO    2
`define TMR2_MODE_CM_HI    3

// ****************************************************************
// Reset values and counts.
// ****************************************************************
`define TMR2_RST_BYTE      8'h00
`define TMR2_RST_WORD      16'h0000
`define TMR2_CNT_MAX       16'hffff
`define TMR2_CM_UP         2'h0
`define TMR2_BAUD_DIV_LAST 4'hf

`endif

/* File: tmr2_fall.sv */
// Falling edge detector for one pin of the timer block.
// Assumes the pin is already synchronous to clk_i.
`timescale 1ns/1ps
module tmr2_fall (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic pin_i,
    output logic      fall_o
);
    logic prev_q;

    // The previous level starts high so a pin held low at reset gives an edge on the first clock.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            prev_q <= 1'b1;
            fall_o <= 1'b0;
        end else begin
            prev_q <= pin_i;
            fall_o <= prev_q & ~pin_i;
        end
    end
endmodule // tmr2_fall

/* File: tmr2_far.sv */
// Far-side model of the timer block: timer one overflow source and the two pins.
// Assumes the bench sets the levels that outside logic would put on the pins.
`timescale 1ns/1ps
module tmr2_far (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic pin_drv_i,
    input  wire logic trig_drv_i,
    input  wire logic dut_pin_i,
    input  wire logic dut_oe_n_i,
    output logic      pin_in_o,
    output logic      trig_o,
    output logic      t1_ovf_o
);
    logic [2:0] div_q;

    // ****************************************************************
    // Timer one source and pin levels.
    // ****************************************************************
    // Timer one overflows every fifth clock, so a receive bit lasts 80 clocks.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_q <= 3'h0;
        end else begin
            div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
        end
    end
    assign t1_ovf_o = (div_q == 3'h4);
    // The pin shows the timer's output while it drives, the outside level otherwise.
    assign pin_in_o = dut_oe_n_i ? pin_drv_i : dut_pin_i;
    assign trig_o   = trig_drv_i;
endmodule // tmr2_far

/* File: tmr2_pkg.sv */
// Types shared by the timer block files.
// Assumes tmr2_cfg.svh is on the include path.
package tmr2_pkg;
    `include "tmr2_cfg.svh"

    // Operating mode as decoded from the control and mode registers.
    typedef enum logic [1:0] {
        TMR2_MODE_CAPTURE,
        TMR2_MODE_RELOAD,
        TMR2_MODE_UPDOWN,
        TMR2_MODE_BAUD
    } tmr2_mode_t;

    typedef logic [2:0] tmr2_addr_t;
    typedef logic [7:0] tmr2_byte_t;
endpackage

/* File: tmr2_top.sv */
// Sixteen-bit timer with capture, auto-reload, up/down, baud generation and
// clock-out. Assumes synchronous pin inputs and a byte register port.
// Contract
// - Direction pin selects up (high) or down (low) when both enables set.
// - Counting up in mode 00, overflow at MAX sets flag and loads reload.
// - Counting down, count equal to reload underflows, sets flag, loads MAX.
// - Up/down mode toggles event flag on each wrap; no interrupt from it.
// - Transmit/receive select bits pick this timer, else timer one.
// - Baud mode reloads both count bytes from reload pair on rollover.
// - Serial bit clock equals overflow rate divided by sixteen.
// - Baud overflow period is 65536 minus reload, in system clocks; here in prescaler enables, one every prescale_setting+1 clocks.
// - Baud mode rollover sets no overflow flag and raises no interrupt.
// - Baud mode external falling edge sets event flag without reload.
// - Baud generation and clock-out run together from one reload pair.
// - Timer select with clock-out enabled toggles the pin every overflow.
// - Run control starts and stops the timer, clock-out included.
// - Clock-out frequency is system clock over twice the period.
// - Clock-out mode rollovers raise no timer interrupt.
// - Timer pin is count input or toggling output by configuration.
// - Serial select bits override capture select, forcing auto-reload.
// - Counter select counts falling edges on the timer pin; here nothing is counted while the clock-out enable bit is set.
// - Up-only reload mode: external falling edge reloads and sets flag.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "tmr2_cfg.svh"
module tmr2_top #(
    parameter int PRESCALE_W = 4
) (
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    input  wire tmr2_pkg::tmr2_addr_t addr_i,
    input  wire tmr2_pkg::tmr2_byte_t wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output tmr2_pkg::tmr2_byte_t      rdata_o,
    input  wire logic                 timer_io_pin_i,
    output logic                      timer_io_pin_o,
    output logic                      timer_io_pin_oe_n_o,
    input  wire logic                 ext_trigger_pin_i,
    input  wire logic                 timer1_ovf_i,
    output logic                      tx_bit_tick_o,
    output logic                      rx_bit_tick_o,
    output logic                      timer_overflow_flag_o,
    output logic                      ext_event_flag_o,
    output logic                      timer_irq_o
);
    import tmr2_pkg::*;

    // ****************************************************************
    // Registers.
    // ****************************************************************
    logic [15:0]           cnt_q;
    logic [15:0]           cnt_d;
    logic [15:0]           rld_q;
    logic [15:0]           rld_d;
    logic [7:0]            ctrl_q;
    logic [3:0]            mode_q;
    logic [PRESCALE_W-1:0] prescale_q;
    logic [PRESCALE_W-1:0] pre_q;
    logic                  tf_d;
    logic                  exf_d;
    logic [3:0]            div_q [2];
    logic [1:0]            bit_tick_q;

    // ****************************************************************
    // Register port decode.
    // ****************************************************************
    wire wr_ctrl = wr_i && (addr_i == `TMR2_OFS_CTRL);
    wire wr_mode = wr_i && (addr_i == `TMR2_OFS_MODE);
    wire wr_clo  = wr_i && (addr_i == `TMR2_OFS_CNT_LO);
    wire wr_chi  = wr_i && (addr_i == `TMR2_OFS_CNT_HI);
    wire wr_rlo  = wr_i && (addr_i == `TMR2_OFS_RLD_LO);
    wire wr_rhi  = wr_i && (addr_i == `TMR2_OFS_RLD_HI);
    wire wr_pre  = wr_i && (addr_i == `TMR2_OFS_PRESCALE);

    // Control and mode fields by name.
    wire cprl    = ctrl_q[`TMR2_CTRL_CPRL];
    wire csel    = ctrl_q[`TMR2_CTRL_CSEL];
    wire run     = ctrl_q[`TMR2_CTRL_RUN];
    wire exen    = ctrl_q[`TMR2_CTRL_EXEN];
    wire txsel   = ctrl_q[`TMR2_CTRL_TXSEL];
    wire rxsel   = ctrl_q[`TMR2_CTRL_RXSEL];
    wire tf_q    = ctrl_q[`TMR2_CTRL_TF];
    wire exf_q   = ctrl_q[`TMR2_CTRL_EXF];
    wire down_en = mode_q[`TMR2_MODE_DOWN];
    wire ckoe    = mode_q[`TMR2_MODE_CKOE];
    wire [1:0] count_mode_field = mode_q[`TMR2_MODE_CM_HI:`TMR2_MODE_CM_LO];

    // ****************************************************************
    // Mode decode.
    // ****************************************************************
    // Serial selects outrank capture select so the baud rate never stalls.
    wire        baud_mode = txsel | rxsel;
    wire        clkout    = ckoe & ~csel;
    tmr2_mode_t mode;
    assign mode = baud_mode ? TMR2_MODE_BAUD :
                  cprl      ? TMR2_MODE_CAPTURE :
                  down_en   ? TMR2_MODE_UPDOWN : TMR2_MODE_RELOAD;

    // Direction only follows the pin with both enables set; else count up.
    wire count_down = (mode == TMR2_MODE_UPDOWN) & exen & ~ext_trigger_pin_i;

    // ****************************************************************
    // Count sources.
    // ****************************************************************
    logic io_fall;
    logic ext_fall;

    tmr2_fall u_io_fall (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (timer_io_pin_i),
        .fall_o  (io_fall)
    );

    tmr2_fall u_ext_fall (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (ext_trigger_pin_i),
        .fall_o  (ext_fall)
    );

    // The prescaler gives one enable every prescale_setting+1 clocks.
    wire pre_tick = (pre_q == prescale_q);
    // Counting the pin is refused while the clock-out enable bit is set, even though the pin is then released.
    wire src_tick = (csel & ~ckoe) ? io_fall : (~csel & pre_tick);
    wire tick     = run & src_tick;

    // ****************************************************************
    // Wrap detection and next count.
    // ****************************************************************
    wire at_max   = (cnt_q == `TMR2_CNT_MAX);
    wire at_rld   = (cnt_q == rld_q);
    wire ovf_up   = tick & ~count_down & at_max;
    wire ovf_dn   = tick & count_down & at_rld;
    wire ovf_evt  = ovf_up | ovf_dn;
    wire ext_evt  = exen & ext_fall & (mode != TMR2_MODE_UPDOWN);
    wire ext_rld  = ext_evt & (mode == TMR2_MODE_RELOAD);
    wire ext_cap  = ext_evt & (mode == TMR2_MODE_CAPTURE);
    // Other count mode codes are reserved and behave like the plain up code.
    wire cm_up    = (count_mode_field == `TMR2_CM_UP) | 1'b1;

    // Next count: software write beats hardware, external reload beats tick.
    always_comb begin
        cnt_d = cnt_q;
        if (ext_rld) begin
            cnt_d = rld_q;
        end else if (ovf_dn) begin
            cnt_d = `TMR2_CNT_MAX;
        end else if (ovf_up && mode != TMR2_MODE_CAPTURE && cm_up) begin
            // Baud and clock-out both reload from the one pair.
            cnt_d = rld_q;
        end else if (tick && count_down) begin
            cnt_d = cnt_q - 16'h0001;
        end else if (tick) begin
            cnt_d = cnt_q + 16'h0001;
        end
        if (wr_clo) begin
            cnt_d[7:0] = wdata_i;
        end
        if (wr_chi) begin
            cnt_d[15:8] = wdata_i;
        end
    end

    // Reload pair: capture loads the count, a software write wins.
    always_comb begin
        rld_d = ext_cap ? cnt_q : rld_q;
        if (wr_rlo) begin
            rld_d[7:0] = wdata_i;
        end
        if (wr_rhi) begin
            rld_d[15:8] = wdata_i;
        end
    end

    // ****************************************************************
    // Flags: a hardware set beats a software clear in the same cycle.
    // ****************************************************************
    always_comb begin
        tf_d  = wr_ctrl ? wdata_i[`TMR2_CTRL_TF] : tf_q;
        exf_d = wr_ctrl ? wdata_i[`TMR2_CTRL_EXF] : exf_q;
        // No overflow flag in baud or clock-out use.
        if (ovf_evt && !baud_mode && !clkout) begin
            tf_d = 1'b1;
        end
        if (ovf_evt && mode == TMR2_MODE_UPDOWN) begin
            exf_d = ~exf_q;
        end else if (ext_evt) begin
            exf_d = 1'b1;
        end
    end

    // ****************************************************************
    // Register state.
    // ****************************************************************
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q  <= `TMR2_RST_WORD;
            rld_q  <= `TMR2_RST_WORD;
            ctrl_q <= `TMR2_RST_BYTE;
            mode_q <= 4'h0;
            prescale_q <= '0;
            pre_q  <= '0;
        end else begin
            cnt_q  <= cnt_d;
            rld_q  <= rld_d;
            ctrl_q <= {tf_d, exf_d, wr_ctrl ? wdata_i[5:0] : ctrl_q[5:0]};
            if (wr_mode) begin
                mode_q <= wdata_i[3:0];
            end
            if (wr_pre) begin
                prescale_q <= wdata_i[PRESCALE_W-1:0];
            end
            // A stopped timer clears its prescaler to zero too, so restarts are clean.
            pre_q  <= (pre_tick || !run) ? '0 : pre_q + 1'b1;
        end
    end

    // ****************************************************************
    // Read data, one cycle after the read strobe.
    // ****************************************************************
    tmr2_byte_t rd_mux;
    assign rd_mux = (addr_i == `TMR2_OFS_CTRL)     ? ctrl_q :
                    (addr_i == `TMR2_OFS_MODE)     ? {4'h0, mode_q} :
                    (addr_i == `TMR2_OFS_CNT_LO)   ? cnt_q[7:0] :
                    (addr_i == `TMR2_OFS_CNT_HI)   ? cnt_q[15:8] :
                    (addr_i == `TMR2_OFS_RLD_LO)   ? rld_q[7:0] :
                    (addr_i == `TMR2_OFS_RLD_HI)   ? rld_q[15:8] :
                    (addr_i == `TMR2_OFS_PRESCALE) ? 8'(prescale_q) : 8'h00;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? rd_mux : 8'h00;
        end
    end

    // ****************************************************************
    // Serial bit clocks: each direction divides its source by sixteen.
    // ****************************************************************
    wire [1:0] dir_sel = {rxsel, txsel};
    for (genvar g = 0; g < 2; g++) begin : g_bit_div
        wire src = dir_sel[g] ? ovf_evt : timer1_ovf_i;
        always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
                div_q[g]      <= 4'h0;
                bit_tick_q[g] <= 1'b0;
            end else begin
                div_q[g]      <= src ? div_q[g] + 4'h1 : div_q[g];
                bit_tick_q[g] <= src && (div_q[g] == `TMR2_BAUD_DIV_LAST);
            end
        end
    end
    assign tx_bit_tick_o = bit_tick_q[0];
    assign rx_bit_tick_o = bit_tick_q[1];

    // ****************************************************************
    // Pin drive, flag outputs and interrupt request.
    // ****************************************************************
    // The pin stays released whenever clock-out is off so it can be an input.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_io_pin_o        <= 1'b0;
            timer_io_pin_oe_n_o   <= 1'b1;
            timer_overflow_flag_o <= 1'b0;
            ext_event_flag_o      <= 1'b0;
            timer_irq_o           <= 1'b0;
        end else begin
            timer_io_pin_oe_n_o   <= ~clkout;
            if (clkout && ovf_evt) begin
                timer_io_pin_o <= ~timer_io_pin_o;
            end
            timer_overflow_flag_o <= tf_d;
            ext_event_flag_o      <= exf_d;
            // The event flag is a count bit in up/down use, never a request.
            timer_irq_o <= tf_d | (exf_d & (mode != TMR2_MODE_UPDOWN));
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    wire no_sw = !wr_i;

    a_up_ovf_reload: assert property (
        (ovf_up && mode == TMR2_MODE_RELOAD && !ext_rld && no_sw)
        |=> (cnt_q == $past(rld_q)) && (tf_q || $past(clkout)))
        else $error("up overflow did not reload and flag");

    a_down_unf_max: assert property (
        (ovf_dn && no_sw) |=> (cnt_q == 16'hffff) && (tf_q || $past(clkout)))
        else $error("underflow did not load all ones");

    a_dir_pin_down: assert property (
        (tick && mode == TMR2_MODE_UPDOWN && exen && !ext_trigger_pin_i && !at_rld && no_sw)
        |=> cnt_q == $past(cnt_q) - 16'h0001)
        else $error("low direction pin did not count down");

    a_exf_toggle_wrap: assert property (
        (ovf_evt && mode == TMR2_MODE_UPDOWN && no_sw)
        |=> (exf_q != $past(exf_q)) ##1 (timer_irq_o == tf_q))
        else $error("event flag did not toggle or raised a request");

    a_baud_no_flag: assert property (
        (ovf_evt && baud_mode && !wr_ctrl) |=> tf_q == $past(tf_q))
        else $error("baud rollover changed overflow flag");

    a_baud_ext_keep: assert property (
        (baud_mode && ext_fall && exen && no_sw)
        |=> exf_q && ($past(at_max) || cnt_q == $past(cnt_q) + 16'($past(tick))))
        else $error("baud external edge reloaded or missed flag");

    a_pin_toggle_ovf: assert property (
        (clkout && ovf_evt) |=> (timer_io_pin_o != $past(timer_io_pin_o)))
        else $error("clock-out pin did not toggle");

    a_stop_holds: assert property (
        (!run && no_sw) |=> $stable(cnt_q))
        else $error("stopped timer changed count");

    a_tx_tick_div: assert property (
        (txsel && ovf_evt && div_q[0] == 4'hf) |=> tx_bit_tick_o)
        else $error("transmit bit tick missing after sixteen wraps");

    // Clock-out wraps must leave the overflow flag alone, or the pin would interrupt.
    a_clkout_no_flag: assert property (
        (ovf_evt && clkout && !wr_ctrl) |=> tf_q == $past(tf_q))
        else $error("clock-out rollover changed overflow flag");

    // In counter use the system clock ticks must not move the count.
    a_pin_count_only: assert property (
        (run && csel && !ckoe && !io_fall && !ext_rld && no_sw) |=> $stable(cnt_q))
        else $error("counter select counted without a pin edge");

    a_baud_reload: assert property (
        (baud_mode && ovf_up && no_sw) |=> cnt_q == $past(rld_q))
        else $error("baud rollover did not reload the pair");
endmodule // tmr2_top
